// File: hw/safety_alert_pkg.sv
// package: offsets, field positions and reset values of the safety alert flags
package safety_alert_pkg;
    localparam logic [7:0] general_alert_offset     = 8'h0b;
    localparam logic [7:0] general_alert_rd_cmd     = 8'h17;
    localparam logic [7:0] general_alert_wr_cmd     = 8'h16;
    localparam logic [7:0] lockstep_alert_rd_cmd    = 8'h15;
    localparam logic [7:0] lockstep_alert_wr_cmd    = 8'h14;
    localparam int         bit_hardware_fault       = 0;
    localparam int         bit_alive_error          = 1;
    localparam int         bit_buffer_mismatch      = 0;
    localparam int         bit_alert_packet_comm    = 1;
    localparam int         bit_restricted_access    = 2;
    localparam int         bit_datapath             = 3;
    localparam int         bit_pin_fault            = 4;
    localparam int         bit_watchdog_fault       = 5;
    localparam int         bit_device_total         = 6;
    localparam logic [7:0] general_alert_reset      = 8'h00;
    localparam logic [1:0] lockstep_alert_reset     = 2'h0;
    localparam logic [7:0] general_alert_used_mask  = 8'h7f;
    typedef enum logic [1:0] {
        alive_off_type_val,
        alive_manual_type_val,
        alive_auto_type_val
    } alive_mode_type;
    typedef enum logic [1:0] {
        cmd_broadcast_type_val,
        cmd_single_type_val,
        cmd_block_type_val
    } alive_cmd_type;
endpackage : safety_alert_pkg

// File: hw/alive_check_if.sv
// interface: alive counter check request and verdict
`timescale 1ns/1ns
`default_nettype none
interface alive_check_if;
    logic                           check;
    safety_alert_pkg::alive_cmd_type kind;
    logic [7:0]                     seed;
    logic [7:0]                     queued;
    logic [7:0]                     returned;
    logic [7:0]                     total;
    logic                           mismatch;
    modport requester (output check, kind, seed, queued, returned, total, input mismatch);
    modport checker_side (input check, kind, seed, queued, returned, total, output mismatch);
endinterface : alive_check_if
`default_nettype wire

// File: hw/alive_check.sv
// alive byte checker: compares the returned alive byte with its expected value
`timescale 1ns/1ns
`default_nettype none
module alive_check (
    alive_check_if.checker_side chk
);
    function automatic logic [7:0] expected_alive(
        input logic [7:0]                      seed,
        input logic [7:0]                      queued,
        input logic [7:0]                      total,
        input safety_alert_pkg::alive_cmd_type kind
    );
        logic [7:0] step;
        step = (kind == safety_alert_pkg::cmd_broadcast_type_val) ? total : 8'h01;
        return 8'(seed - queued + step); // RULE1
    endfunction : expected_alive

    always_comb begin
        chk.mismatch = chk.check &&
            (chk.returned != expected_alive(chk.seed, chk.queued, chk.total, chk.kind)); // RULE1
    end
endmodule : alive_check
`default_nettype wire

// File: hw/safety_alert_flags.sv
// safety alert flags: lock-step alive/hardware bits and the general alert register
// Overview of operation
// [RULE1] auto alive mode: mismatch of returned byte against seed minus queue plus step flags
// [RULE2] seed clear requested with non-zero alive queue count also sets alive error
// [RULE3] alive error never sets while alive counting is off or manual
// [RULE4] alive error is event driven: write 0 clears, write 1 leaves it
// [RULE5] hardware fault flag bit 0 sets on supply, oscillator or transient logic fault
// [RULE6] hardware fault flag persists while its underlying status stays set
// [RULE7] device total mismatch flag bit 6 sets when returned total differs from expected
// [RULE8] restricted access flag bit 2 sets on forbidden access; event driven
// [RULE9] watchdog summary bit 5 and pin summary bit 4 are ORs, persistent
`timescale 1ns/1ns
`default_nettype none
module safety_alert_flags (
    // clock and reset
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    // register access decoded from the serial host port
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    input  wire logic [7:0]                      reg_cmd,
    input  wire logic [7:0]                      reg_wdata,
    output var  logic [7:0]                      reg_rdata,
    // alive counter
    input  wire safety_alert_pkg::alive_mode_type alive_mode,
    input  wire logic                            alive_return_valid,
    input  wire safety_alert_pkg::alive_cmd_type alive_cmd_kind,
    input  wire logic [7:0]                      returned_alive_byte,
    input  wire logic [7:0]                      alive_seed,
    input  wire logic [7:0]                      alive_queue_count,
    input  wire logic                            seed_clear_request,
    // device total check
    input  wire logic [7:0]                      expected_device_total,
    input  wire logic                            returned_total_valid,
    input  wire logic [7:0]                      returned_device_total,
    // fault status sources
    input  wire logic                            supply_fault,
    input  wire logic                            oscillator_fault,
    input  wire logic                            transient_logic_fault,
    input  wire logic [3:0]                      watchdog_errors,
    input  wire logic [3:0]                      pin_errors,
    input  wire logic                            datapath_status,
    input  wire logic                            alert_packet_comm_status,
    input  wire logic                            buffer_mismatch_status,
    input  wire logic                            restricted_mode,
    input  wire logic                            restricted_reg_access,
    // flag outputs
    output var  logic [7:0]                      general_alert_flags,
    output var  logic [1:0]                      lockstep_alert_flags
);
    // widths of the two flag registers that the package field positions index, and of the fault source vectors
    localparam int flag_width     = 8;
    localparam int lockstep_width = 2;
    localparam int source_width   = 4;

    // a field placed outside its register would silently read back as zero
    if (safety_alert_pkg::bit_device_total      >= flag_width ||
        safety_alert_pkg::bit_watchdog_fault    >= flag_width ||
        safety_alert_pkg::bit_pin_fault         >= flag_width ||
        safety_alert_pkg::bit_datapath          >= flag_width ||
        safety_alert_pkg::bit_restricted_access >= flag_width ||
        safety_alert_pkg::bit_alert_packet_comm >= flag_width ||
        safety_alert_pkg::bit_buffer_mismatch   >= flag_width ||
        safety_alert_pkg::bit_alive_error       >= lockstep_width ||
        safety_alert_pkg::bit_hardware_fault    >= lockstep_width ||
        $bits(watchdog_errors) != source_width ||
        $bits(pin_errors) != source_width) begin : g_field_check
        $error("alert field or source width does not fit its register");
    end

    // command decode shared by both write strobes
    function automatic logic cmd_hit(
        input logic       strobe,
        input logic [7:0] cmd,
        input logic [7:0] code
    );
        return strobe && (cmd == code);
    endfunction : cmd_hit

    function automatic logic any_source(
        input logic [3:0] sources
    );
        return |sources;
    endfunction : any_source

    function automatic logic [7:0] lockstep_byte(
        input logic [1:0] flags
    );
        return {6'h00, flags};
    endfunction : lockstep_byte

    // write 0 clears, write 1 keeps; a set term in the same cycle wins so no event is lost
    function automatic logic [7:0] clear_then_set(
        input logic [7:0] held,
        input logic       write_hit,
        input logic [7:0] wdata,
        input logic [7:0] set_terms
    );
        logic [7:0] kept;
        kept = write_hit ? (held & wdata) : held;
        return kept | set_terms;
    endfunction : clear_then_set

    alive_check_if alive_bus ();

    alive_check u_alive_check (
        .chk (alive_bus)
    );

    // state of each group and its next value
    logic       seed_clear_seen;
    logic       next_seed_clear_seen;
    logic       seed_clear_edge;
    logic       alive_auto;
    logic       general_wr;
    logic       lockstep_wr;
    logic [1:0] lockstep_set;
    logic [7:0] lockstep_update;
    logic [1:0] next_lockstep_alert_flags;
    logic [7:0] general_set;
    logic [7:0] next_general_alert_flags;
    logic [7:0] next_reg_rdata;

    assign alive_bus.check    = alive_return_valid;
    assign alive_bus.kind     = alive_cmd_kind;
    assign alive_bus.seed     = alive_seed;
    assign alive_bus.queued   = alive_queue_count;
    assign alive_bus.returned = returned_alive_byte;
    assign alive_bus.total    = expected_device_total;

    always_comb begin
        alive_auto  = (alive_mode == safety_alert_pkg::alive_auto_type_val); // RULE3
        general_wr  = cmd_hit(reg_wr, reg_cmd, safety_alert_pkg::general_alert_wr_cmd);
        lockstep_wr = cmd_hit(reg_wr, reg_cmd, safety_alert_pkg::lockstep_alert_wr_cmd);
    end

    // the seed clear request counts once, as it rises; a request held high must not
    // re-arm an event-driven flag that the host has just cleared
    always_comb begin
        next_seed_clear_seen = seed_clear_request;
        seed_clear_edge      = seed_clear_request && !seed_clear_seen; // RULE2 RULE4
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seed_clear_seen <= 1'b0;
        end else begin
            seed_clear_seen <= next_seed_clear_seen;
        end
    end

    // alive error is event driven; hardware fault is held up by its live status
    always_comb begin
        lockstep_set = '0;
        lockstep_set[safety_alert_pkg::bit_alive_error] = alive_auto && // RULE3
            (alive_bus.mismatch || // RULE1
             (seed_clear_edge && (alive_queue_count != 8'h00))); // RULE2
        lockstep_set[safety_alert_pkg::bit_hardware_fault] =
            supply_fault || oscillator_fault || transient_logic_fault; // RULE5 RULE6
        lockstep_update = clear_then_set(lockstep_byte(lockstep_alert_flags), lockstep_wr,
            reg_wdata, lockstep_byte(lockstep_set)); // RULE4 RULE6
        next_lockstep_alert_flags = lockstep_update[1:0];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lockstep_alert_flags <= safety_alert_pkg::lockstep_alert_reset;
        end else begin
            lockstep_alert_flags <= next_lockstep_alert_flags;
        end
    end

    // persistent bits are re-set every cycle while their live status stays high
    always_comb begin
        general_set = '0;
        general_set[safety_alert_pkg::bit_buffer_mismatch]   = buffer_mismatch_status;
        general_set[safety_alert_pkg::bit_alert_packet_comm] = alert_packet_comm_status;
        general_set[safety_alert_pkg::bit_restricted_access] =
            restricted_mode && restricted_reg_access; // RULE8
        general_set[safety_alert_pkg::bit_datapath]          = datapath_status;
        general_set[safety_alert_pkg::bit_pin_fault]         = any_source(pin_errors); // RULE9
        general_set[safety_alert_pkg::bit_watchdog_fault]    =
            any_source(watchdog_errors); // RULE9
        general_set[safety_alert_pkg::bit_device_total]      = returned_total_valid &&
            (returned_device_total != expected_device_total); // RULE7
        next_general_alert_flags = clear_then_set(general_alert_flags, general_wr, reg_wdata,
            general_set) & safety_alert_pkg::general_alert_used_mask; // RULE8 RULE9
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            general_alert_flags <= safety_alert_pkg::general_alert_reset;
        end else begin
            general_alert_flags <= next_general_alert_flags;
        end
    end

    // read data holds until the next read; an unknown command reads back as zero
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_cmd)
                safety_alert_pkg::general_alert_rd_cmd: begin
                    next_reg_rdata = general_alert_flags;
                end
                safety_alert_pkg::lockstep_alert_rd_cmd: begin
                    next_reg_rdata = lockstep_byte(lockstep_alert_flags);
                end
                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule : safety_alert_flags
`default_nettype wire

// File: tb/safety_alert_assertions.sv
// checker: timing of the safety alert flag outputs against their causes
`timescale 1ns/1ns
`default_nettype none
module safety_alert_checker (
    input wire logic       mclk, rst_n, reg_wr, alive_return_valid, seed_clear_request,
    input wire logic       returned_total_valid, supply_fault, oscillator_fault,
    input wire logic       transient_logic_fault, restricted_mode, restricted_reg_access,
    input wire logic [7:0] reg_cmd, reg_wdata, returned_alive_byte, alive_seed,
    input wire logic [7:0] alive_queue_count, expected_device_total, returned_device_total,
    input wire logic [7:0] general_alert_flags,
    input wire logic [3:0] watchdog_errors,
    input wire logic [1:0] lockstep_alert_flags,
    input wire safety_alert_pkg::alive_mode_type alive_mode,
    input wire safety_alert_pkg::alive_cmd_type  alive_cmd_kind
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire       in_auto = alive_mode == safety_alert_pkg::alive_auto_type_val;
    // broadcast steps by the whole chain, every other kind by one
    wire [7:0] want = alive_seed - alive_queue_count + (alive_cmd_kind ==
        safety_alert_pkg::cmd_broadcast_type_val ? expected_device_total : 8'h01);
    alive_wrong_a: assert property (
        alive_return_valid && in_auto && returned_alive_byte != want
        |=> lockstep_alert_flags[1]) else $error("alive mismatch not flagged");
    seed_clear_a: assert property (
        in_auto && $rose(seed_clear_request) && alive_queue_count != 0
        |=> lockstep_alert_flags[1]) else $error("seed clear not flagged");
    alive_quiet_a: assert property (
        !in_auto && !lockstep_alert_flags[1]
        |=> !lockstep_alert_flags[1]) else $error("alive error outside auto");
    alive_clear_a: assert property (
        (!in_auto || (!alive_return_valid && !$rose(seed_clear_request))) && reg_wr &&
        !reg_wdata[1] && reg_cmd == safety_alert_pkg::lockstep_alert_wr_cmd
        |=> !lockstep_alert_flags[1]) else $error("alive error not cleared");
    hw_fault_a: assert property (
        supply_fault || oscillator_fault || transient_logic_fault
        |=> lockstep_alert_flags[0]) else $error("hardware fault not held");
    count_error_a: assert property (
        returned_total_valid && returned_device_total != expected_device_total
        |=> general_alert_flags[6]) else $error("total not flagged");
    restricted_a: assert property (
        restricted_mode && restricted_reg_access
        |=> general_alert_flags[2]) else $error("restricted access not flagged");
    wd_summary_a: assert property (
        |watchdog_errors |=> general_alert_flags[5]) else $error("watchdog summary not held");
    cover property (lockstep_alert_flags[1]);
    cover property (general_alert_flags[6]);
    cover property (lockstep_alert_flags[0] && reg_wr);
endmodule : safety_alert_checker
bind safety_alert_flags safety_alert_checker i_chk (.*);
`default_nettype wire

// File: tb/host_model.sv
// host model: register strobes as the serial host port presents them
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_cmd,
    output var  logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_cmd, reg_wdata} = '0;
    task automatic access(input logic wr, input logic [7:0] cmd, d, output logic [7:0] q);
        @(posedge mclk);
        #1 {reg_wr, reg_rd, reg_cmd, reg_wdata} = {wr, !wr, cmd, d};
        @(posedge mclk);
        // stale data is inverted so a late sample cannot pass by luck
        #1 q = reg_rdata;
        {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
    endtask : access
endmodule : host_model
`default_nettype wire

// File: tb/safety_alert_flags_test.sv
// testbench: set, hold and clear of the safety alert flags over the register port
`timescale 1ns/1ns
`default_nettype none
module safety_alert_flags_test;
    logic mclk = 0, rst_n = 0, reg_wr, reg_rd, alive_return_valid = 0, seed_clear_request = 0;
    logic returned_total_valid = 0, restricted_mode = 0, restricted_reg_access = 0;
    logic [7:0] reg_cmd, reg_wdata, reg_rdata, general_alert_flags, rd, returned_alive_byte = 0;
    logic [7:0] alive_seed = 8'h0a, alive_queue_count = 8'h03, expected_device_total = 8'h05;
    logic [7:0] returned_device_total = 0, ab [6] = '{8'h0c, 8'h0d, 8'h08, 8'h09, 8'h08, 8'h07};
    logic [10:0] src = 0;
    logic [2:0] f = 0;
    logic [1:0] lockstep_alert_flags;
    safety_alert_pkg::alive_mode_type alive_mode = safety_alert_pkg::alive_auto_type_val;
    safety_alert_pkg::alive_cmd_type alive_cmd_kind;
    int n_fail = 0, n_compared = 0, cyc = 0;
    safety_alert_flags i_dut (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata, .reg_rdata,
        .alive_mode, .alive_return_valid, .alive_cmd_kind, .returned_alive_byte, .alive_seed,
        .alive_queue_count, .seed_clear_request, .expected_device_total, .returned_total_valid,
        .returned_device_total, .supply_fault(f[0]), .oscillator_fault(f[1]),
        .transient_logic_fault(f[2]), .watchdog_errors(src[10:7]), .pin_errors(src[6:3]),
        .datapath_status(src[2]), .alert_packet_comm_status(src[1]),
        .buffer_mismatch_status(src[0]), .restricted_mode, .restricted_reg_access,
        .general_alert_flags, .lockstep_alert_flags);
    host_model i_host (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata);
    initial forever #10 mclk = ~mclk;
    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic rdc(input logic [7:0] cmd, exp);
        i_host.access(1'b0, cmd, 8'h00, rd);
        n_compared++;
        if (rd !== exp) begin
            n_fail++;
            $display("unexpected at %0t: read %h, wanted %h", $time, rd, exp);
        end
    endtask : rdc
    task automatic wr(input logic [7:0] cmd, d);
        i_host.access(1'b1, cmd, d, rd);
    endtask : wr
    task automatic pulse(ref logic s);
        @(posedge mclk);
        #1 s = 1;
        @(posedge mclk);
        #1 s = 0;
    endtask : pulse
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_n = 1;
        rdc(8'h15, 8'h00);
        rdc(8'h17, 8'h00);
        rdc(8'h99, 8'h00);
        for (int i = 0; i < 6; i++) begin
            alive_cmd_kind = safety_alert_pkg::alive_cmd_type'(i / 2);
            returned_alive_byte = ab[i];
            pulse(alive_return_valid);
            rdc(8'h15, i % 2 ? 8'h02 : 8'h00);
            wr(8'h14, 8'h02);
            rdc(8'h15, i % 2 ? 8'h02 : 8'h00);
            wr(8'h14, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            alive_queue_count = i ? 8'h00 : 8'h03;
            seed_clear_request = 1;
            rdc(8'h15, i ? 8'h00 : 8'h02);
            wr(8'h14, 8'h00);
            rdc(8'h15, 8'h00);
            seed_clear_request = 0;
        end
        $display("test alive done");
        // wrong byte and seed clear together, with counting manual then off
        alive_queue_count = 8'h03;
        for (int i = 0; i < 2; i++) begin
            alive_mode = safety_alert_pkg::alive_mode_type'(1 - i);
            seed_clear_request = 1;
            pulse(alive_return_valid);
            rdc(8'h15, 8'h00);
            seed_clear_request = 0;
            wr(8'h14, 8'h00);
        end
        $display("test alive off done");
        for (int j = 0; j < 3; j++) begin
            f = 3'b001 << j;
            wr(8'h14, 8'h00);
            rdc(8'h15, 8'h01);
            f = 0;
            wr(8'h14, 8'h00);
            rdc(8'h15, 8'h00);
        end
        $display("test hardware fault done");
        for (int k = 0; k < 2; k++) begin
            returned_device_total = k ? 8'h05 : 8'h04;
            restricted_mode = !k;
            pulse(returned_total_valid);
            pulse(restricted_reg_access);
            rdc(8'h17, k ? 8'h00 : 8'h44);
            wr(8'h16, 8'h00);
        end
        $display("test total and restricted done");
        for (int j = 0; j < 11; j++) begin
            src = 11'h001 << j;
            wr(8'h16, 8'h00);
            rdc(8'h17, j > 6 ? 8'h20 : j > 2 ? 8'h10 : 8'h01 << (j == 2 ? 3 : j));
            src = 0;
            wr(8'h16, 8'h00);
        end
        rdc(8'h17, 8'h00);
        $display("test summaries done");
        tally_and_finish();
    end
endmodule : safety_alert_flags_test
`default_nettype wire
